// >>> core/hpc_config_regs.sv
`timescale 1ns/1ps
`include "hpc_params.svh"
module hpc_config_regs
  import hpc_pkg::*;
#(
  parameter int SLOTS = 6,
  parameter logic [4:0] HW_SLOT_COUNT = 5'h06
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic regReq,
  input wire logic regWr,
  input wire logic regCfgSpace,
  input wire logic [7:0] regAddr,
  input wire hpc_be_t regBe,
  input wire hpc_word_t regWrData,
  output hpc_word_t regRdData,
  output logic regAck,
  input wire logic [2:0] busSpeedMode,
  input wire logic [4:0] msgNumber,
  input wire hpc_word_t intSourceMap,
  input wire hpc_word_t serrSourceMap,
  input wire logic [1:0] errEvent,
  input wire logic cmdDone,
  output logic cmdStart,
  output logic [7:0] commandCode,
  output logic [4:0] targetSlot,
  output logic attentionButtonPresent,
  output logic latchSensorPresent,
  output logic [4:0] firstSlotDeviceNumber,
  output logic [4:0] slotCount,
  output logic hotPlugCapPresent,
  output hpc_label_t slotLabel [SLOTS],
  output logic [3:0] errIntEnable
);
  hpc_slot_if slotBus ();

  hpc_slot_mem #(
    .SLOTS(SLOTS)
  ) u_slot_mem (
    .mclk(mclk),
    .rst_b(rst_b),
    .bus(slotBus)
  );

  hpc_word_t availFirst_ff, nxt_availFirst;
  hpc_word_t availSecond_ff, nxt_availSecond;
  hpc_word_t layout_ff, nxt_layout;
  logic [2:0] locked_ff, nxt_locked;
  logic [15:0] cmd_ff, nxt_cmd;
  logic [15:0] cmdState_ff, nxt_cmdState;
  hpc_word_t errEnable_ff, nxt_errEnable;
  logic cmdStart_ff, nxt_cmdStart;
  logic ack_ff, nxt_ack;
  logic rdFromMem_ff, nxt_rdFromMem;
  hpc_word_t rdHold_ff, nxt_rdHold;
  hpc_label_t label_ff [SLOTS];
  hpc_label_t nxt_label [SLOTS];
  logic capPresent_ff, nxt_capPresent;
  logic [4:0] effCount;
  logic isLslot;
  hpc_slot_idx_t lslotIdx;

  // byte-lane merge, shared by the write-once words and the error enable
  function automatic hpc_word_t merge(input hpc_word_t old, input hpc_word_t wdata, input hpc_be_t be,
                                      input hpc_word_t wmask);
    hpc_word_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = (wdata[b*8 +: 8] & wmask[b*8 +: 8]) | (old[b*8 +: 8] & ~wmask[b*8 +: 8]);
      end
    end
    return res;
  endfunction : merge

  // external label of slot n: base label stepped by n in the chosen direction
  function automatic hpc_label_t labelOf(input hpc_label_t base, input logic up, input int n);
    hpc_label_t step;
    step = hpc_label_t'(n);
    return up ? hpc_label_t'(base + step) : hpc_label_t'(base - step);
  endfunction : labelOf

  // a zero stored count is never shown; the strapped count stands in
  assign effCount = (layout_ff[`HPC_CNT_MSB:`HPC_CNT_LSB] != 5'h00) ?
                    layout_ff[`HPC_CNT_MSB:`HPC_CNT_LSB] : HW_SLOT_COUNT;

  // logical slot window decode
  always_comb begin
    isLslot = (regAddr[7:2] >= 6'(`HPC_OFF_LSLOT_FIRST >> 2)) &&
              (regAddr[7:2] <= 6'(`HPC_OFF_LSLOT_LAST >> 2));
    lslotIdx = hpc_slot_idx_t'(regAddr[7:2] - 6'(`HPC_OFF_LSLOT_FIRST >> 2));
  end

  assign slotBus.wrEn = regReq && regWr && isLslot;
  assign slotBus.wrIdx = lslotIdx;
  assign slotBus.wrData = regWrData;
  assign slotBus.wrBe = regBe;
  assign slotBus.rdIdx = lslotIdx;

  // write side: write-once words, command, error enable
  always_comb begin
    logic wr;
    logic [7:0] dw;
    wr = regReq && regWr;
    dw = {regAddr[7:2], 2'b00};
    nxt_availFirst = availFirst_ff;
    nxt_availSecond = availSecond_ff;
    nxt_layout = layout_ff;
    nxt_locked = locked_ff;
    nxt_cmd = cmd_ff;
    nxt_cmdState = cmdState_ff;
    nxt_errEnable = errEnable_ff;
    nxt_cmdStart = 1'b0;
    // a later write is dropped silently until reset
    if (wr && (dw == `HPC_OFF_SLOTS_AVAILABLE_FIRST) && !locked_ff[0] && (regBe != 4'h0)) begin
      nxt_availFirst = merge(availFirst_ff, regWrData, regBe, 32'hffffffff);
      nxt_locked[0] = 1'b1;
    end
    if (wr && (dw == `HPC_OFF_SLOTS_AVAILABLE_SECOND) && !locked_ff[1] && (regBe != 4'h0)) begin
      nxt_availSecond = merge(availSecond_ff, regWrData, regBe, 32'hffffffff);
      nxt_locked[1] = 1'b1;
    end
    // reserved bits of the layout word stay zero
    if (wr && (dw == `HPC_OFF_SLOT_LAYOUT) && !locked_ff[2] && (regBe != 4'h0)) begin
      nxt_layout = merge(layout_ff, regWrData, regBe, `HPC_LAYOUT_WMASK);
      nxt_locked[2] = 1'b1;
    end
    // command code lane starts the command; target slot may be written alone
    if (wr && (dw == `HPC_OFF_CMD)) begin
      nxt_cmd[7:0] = regBe[0] ? regWrData[7:0] : cmd_ff[7:0];
      nxt_cmd[12:8] = regBe[1] ? regWrData[12:8] : cmd_ff[12:8];
      nxt_cmdStart = regBe[0];
    end
    // busy: start sets, done clears, start wins a tie
    if (cmdDone) begin
      nxt_cmdState[`HPC_STS_BUSY] = 1'b0;
    end
    if (nxt_cmdStart) begin
      nxt_cmdState[`HPC_STS_BUSY] = 1'b1;
    end
    if (wr && (dw == `HPC_OFF_ERR_ENABLE)) begin
      nxt_errEnable = merge(errEnable_ff, regWrData, regBe, `HPC_ERR_RW_MASK);
      for (int b = 0; b < 4; b++) begin
        if (regBe[b]) begin
          nxt_errEnable[b*8 +: 8] = nxt_errEnable[b*8 +: 8] & ~(regWrData[b*8 +: 8] & 8'(`HPC_ERR_W1C_MASK >> (b*8)));
        end
      end
    end
    // an event landing with its clear still sets the flag
    nxt_errEnable[`HPC_ERR_EVT_LSB +: 2] = nxt_errEnable[`HPC_ERR_EVT_LSB +: 2] | errEvent;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      availFirst_ff <= `HPC_RST_WORD;
      availSecond_ff <= `HPC_RST_WORD;
      layout_ff <= `HPC_RST_WORD;
      locked_ff <= 3'h0;
      cmd_ff <= 16'h0000;
      cmdState_ff <= 16'h0000;
      errEnable_ff <= `HPC_RST_ERR_ENABLE;
      cmdStart_ff <= 1'b0;
    end else begin
      availFirst_ff <= nxt_availFirst;
      availSecond_ff <= nxt_availSecond;
      layout_ff <= nxt_layout;
      locked_ff <= nxt_locked;
      cmd_ff <= nxt_cmd;
      cmdState_ff <= nxt_cmdState;
      errEnable_ff <= nxt_errEnable;
      cmdStart_ff <= nxt_cmdStart;
    end
  end

  // read side: word held one cycle, answered with ack
  always_comb begin
    logic [7:0] dw;
    dw = {regAddr[7:2], 2'b00};
    nxt_ack = regReq;
    nxt_rdFromMem = regReq && !regWr && isLslot;
    nxt_rdHold = `HPC_RST_WORD;
    if (regReq && !regWr) begin
      case (dw)
        // working set starts right at the base address
        `HPC_OFF_BASE_OFFSET: nxt_rdHold = `HPC_RST_WORD;
        `HPC_OFF_SLOTS_AVAILABLE_FIRST: nxt_rdHold = availFirst_ff;
        `HPC_OFF_SLOTS_AVAILABLE_SECOND: nxt_rdHold = availSecond_ff;
        `HPC_OFF_SLOT_LAYOUT: nxt_rdHold = {layout_ff[31:5], effCount};
        `HPC_OFF_BUS_MODE: nxt_rdHold = {`HPC_RST_FORMAT_ID, 3'h0, msgNumber, 13'h0000, busSpeedMode};
        `HPC_OFF_CMD: nxt_rdHold = {cmdState_ff, cmd_ff};
        `HPC_OFF_INT_MAP: nxt_rdHold = intSourceMap;
        `HPC_OFF_SERR_MAP: nxt_rdHold = serrSourceMap;
        `HPC_OFF_ERR_ENABLE: nxt_rdHold = errEnable_ff;
        default: nxt_rdHold = `HPC_RST_WORD; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdFromMem_ff <= 1'b0;
      rdHold_ff <= `HPC_RST_WORD;
    end else begin
      ack_ff <= nxt_ack;
      rdFromMem_ff <= nxt_rdFromMem;
      rdHold_ff <= nxt_rdHold;
    end
  end

  // labels and capability flag registered so outputs do not glitch
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      nxt_label[i] = labelOf(layout_ff[`HPC_PSL_MSB:`HPC_PSL_LSB], layout_ff[`HPC_BIT_LABEL_DIR], i);
    end
    nxt_capPresent = (effCount != 5'h00);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        label_ff[i] <= 11'h000;
      end
      capPresent_ff <= 1'b0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        label_ff[i] <= nxt_label[i];
      end
      capPresent_ff <= nxt_capPresent;
    end
  end

  // both read sources are flops; memory word picked only for its window
  assign regRdData = rdFromMem_ff ? slotBus.rdData : rdHold_ff;
  assign regAck = ack_ff;
  assign cmdStart = cmdStart_ff;
  assign commandCode = cmd_ff[7:0];
  assign targetSlot = cmd_ff[12:8];
  assign attentionButtonPresent = layout_ff[`HPC_BIT_ATTN_BUTTON];
  assign latchSensorPresent = layout_ff[`HPC_BIT_LATCH_SENSOR];
  assign firstSlotDeviceNumber = layout_ff[`HPC_FDN_MSB:`HPC_FDN_LSB];
  assign slotCount = effCount;
  assign hotPlugCapPresent = capPresent_ff;
  assign slotLabel = label_ff;
  assign errIntEnable = errEnable_ff[3:0];
endmodule : hpc_config_regs

// >>> core/hpc_params.svh
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

// byte offsets of the dwords and of the sub-dword fields in the controller register map
`define HPC_OFF_BASE_OFFSET 8'h00
`define HPC_OFF_SLOTS_AVAILABLE_FIRST 8'h04
`define HPC_OFF_SLOTS_AVAILABLE_SECOND 8'h08
`define HPC_OFF_SLOT_LAYOUT 8'h0c
`define HPC_OFF_BUS_MODE 8'h10
`define HPC_OFF_MSG_NUM 8'h12
`define HPC_OFF_FORMAT_ID 8'h13
`define HPC_OFF_CMD 8'h14
`define HPC_OFF_CMD_STATE 8'h16
`define HPC_OFF_INT_MAP 8'h18
`define HPC_OFF_SERR_MAP 8'h1c
`define HPC_OFF_ERR_ENABLE 8'h20
`define HPC_OFF_LSLOT_FIRST 8'h24
`define HPC_OFF_LSLOT_LAST 8'h38

// slot layout field positions
`define HPC_BIT_ATTN_BUTTON 31
`define HPC_BIT_LATCH_SENSOR 30
`define HPC_BIT_LABEL_DIR 29
`define HPC_PSL_MSB 26
`define HPC_PSL_LSB 16
`define HPC_FDN_MSB 12
`define HPC_FDN_LSB 8
`define HPC_CNT_MSB 4
`define HPC_CNT_LSB 0
`define HPC_LAYOUT_WMASK 32'he7ff1f1f

// reset values
`define HPC_RST_WORD 32'h00000000
`define HPC_RST_FORMAT_ID 8'h01
`define HPC_RST_ERR_ENABLE 32'h0000000f
`define HPC_RST_LSLOT_HIGH 16'h8f00

// error enable layout: rw mask bits and w1c sticky event bits
`define HPC_ERR_RW_MASK 32'h0000000f
`define HPC_ERR_W1C_MASK 32'h00030000
`define HPC_ERR_EVT_LSB 16

// command state bits
`define HPC_STS_BUSY 0

`endif

// >>> core/hpc_pkg.sv
package hpc_pkg;
  typedef logic [31:0] hpc_word_t;
  typedef logic [3:0] hpc_be_t;
  typedef logic [10:0] hpc_label_t;
  typedef logic [2:0] hpc_slot_idx_t;
endpackage : hpc_pkg

// >>> core/hpc_slot_if.sv
`timescale 1ns/1ps
interface hpc_slot_if;
  import hpc_pkg::*;
  logic wrEn;
  hpc_slot_idx_t wrIdx;
  hpc_word_t wrData;
  hpc_be_t wrBe;
  hpc_slot_idx_t rdIdx;
  hpc_word_t rdData;
  modport ctl (output wrEn, output wrIdx, output wrData, output wrBe, output rdIdx, input rdData);
  modport mem (input wrEn, input wrIdx, input wrData, input wrBe, input rdIdx, output rdData);
endinterface : hpc_slot_if

// >>> core/hpc_slot_mem.sv
`timescale 1ns/1ps
`include "hpc_params.svh"
module hpc_slot_mem
  import hpc_pkg::*;
#(
  parameter int SLOTS = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  hpc_slot_if.mem bus
);
  hpc_word_t mem_ff [SLOTS];
  hpc_word_t nxt_mem [SLOTS];
  hpc_word_t rdData_ff;
  hpc_word_t nxt_rdData;

  // byte-lane merge of the write word; read is registered
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      nxt_mem[i] = mem_ff[i];
      if (bus.wrEn && (int'(bus.wrIdx) == i)) begin
        for (int b = 0; b < 4; b++) begin
          if (bus.wrBe[b]) begin
            nxt_mem[i][b*8 +: 8] = bus.wrData[b*8 +: 8];
          end
        end
      end
    end
    nxt_rdData = (int'(bus.rdIdx) < SLOTS) ? mem_ff[bus.rdIdx] : `HPC_RST_WORD;
  end

  // lower half resets to the slot's own ordinal, one-based
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        mem_ff[i] <= {`HPC_RST_LSLOT_HIGH, 16'(i + 1)};
      end
      rdData_ff <= `HPC_RST_WORD;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      rdData_ff <= nxt_rdData;
    end
  end

  assign bus.rdData = rdData_ff;
endmodule : hpc_slot_mem

// >>> testbench/hpc_config_regs_checker.sv
`timescale 1ns/1ps
module hpc_config_regs_checker
  import hpc_pkg::*;
#(
  parameter int SLOTS = 6,
  parameter logic [4:0] HW_SLOT_COUNT = 5'h06
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic regReq,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire hpc_be_t regBe,
  input wire hpc_word_t regWrData,
  input wire hpc_word_t regRdData,
  input wire logic regAck,
  input wire logic cmdStart,
  input wire logic [7:0] commandCode,
  input wire logic [4:0] slotCount,
  input wire logic hotPlugCapPresent,
  input wire hpc_label_t slotLabel [SLOTS],
  input wire logic [3:0] errIntEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // write data lanes kept as plain signals for the sampled-value calls
  wire logic [7:0] wrLow = regWrData[7:0];
  wire logic [3:0] wrNib = regWrData[3:0];
  wire logic rdReq = regReq && !regWr;
  wire logic wrReq = regReq && regWr;
  chk_ack_after_req: assert property (regReq |=> regAck) else $error("no ack after request");
  chk_base_reads_zero: assert property (rdReq && regAddr[7:2] == 6'h00 |=> regRdData == 32'h0)
    else $error("base offset not zero");
  chk_format_id_value: assert property (rdReq && regAddr[7:2] == 6'h04 |=> regRdData[31:24] == 8'h01)
    else $error("format id wrong");
  chk_cmd_code_start: assert property (wrReq && regAddr[7:2] == 6'h05 && regBe[0]
    |=> cmdStart && commandCode == $past(wrLow)) else $error("command start missing");
  chk_count_never_zero: assert property (slotCount != 5'h00) else $error("slot count zero");
  chk_cap_entry_shown: assert property ($past(rst_b) |-> hotPlugCapPresent) else $error("capability hidden");
  // labels step by one in a single direction, so differences must agree
  chk_label_step_one: assert property ($past(rst_b) |-> (slotLabel[2] - slotLabel[1] == slotLabel[1] - slotLabel[0])
    && (slotLabel[1] - slotLabel[0] == 11'h001 || slotLabel[1] - slotLabel[0] == 11'h7ff))
    else $error("label step wrong");
  chk_err_enable_write: assert property (wrReq && regAddr[7:2] == 6'h08 && regBe[0]
    |=> errIntEnable == $past(wrNib)) else $error("error enable not written");
  cov_layout_write: cover property (wrReq && regAddr[7:2] == 6'h03);
  cov_cmd_start: cover property (cmdStart);
  cov_slot_read: cover property (rdReq && regAddr[7:2] == 6'h09);
endmodule : hpc_config_regs_checker

bind hpc_config_regs hpc_config_regs_checker #(.SLOTS(SLOTS), .HW_SLOT_COUNT(HW_SLOT_COUNT)) i_chk (
  .mclk(mclk), .rst_b(rst_b), .regReq(regReq), .regWr(regWr), .regAddr(regAddr), .regBe(regBe),
  .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck), .cmdStart(cmdStart),
  .commandCode(commandCode), .slotCount(slotCount), .hotPlugCapPresent(hotPlugCapPresent),
  .slotLabel(slotLabel), .errIntEnable(errIntEnable));

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import hpc_pkg::*;
  logic mclk, rst_b, regReq, regWr, regCfgSpace, cmdDone, cmdStart, regAck, startSeen;
  logic attentionButtonPresent, latchSensorPresent, hotPlugCapPresent;
  logic [7:0] regAddr, commandCode;
  logic [2:0] busSpeedMode;
  logic [4:0] msgNumber, targetSlot, firstSlotDeviceNumber, slotCount;
  logic [1:0] errEvent;
  logic [3:0] errIntEnable;
  hpc_be_t regBe;
  hpc_word_t regWrData, regRdData, intSourceMap, serrSourceMap, q;
  hpc_label_t slotLabel [6];
  int n_mismatch, n_tests, cycles;
  hpc_config_regs i_dut (.mclk(mclk), .rst_b(rst_b), .regReq(regReq), .regWr(regWr), .regCfgSpace(regCfgSpace),
    .regAddr(regAddr), .regBe(regBe), .regWrData(regWrData), .regRdData(regRdData), .regAck(regAck),
    .busSpeedMode(busSpeedMode), .msgNumber(msgNumber), .intSourceMap(intSourceMap),
    .serrSourceMap(serrSourceMap), .errEvent(errEvent), .cmdDone(cmdDone), .cmdStart(cmdStart),
    .commandCode(commandCode), .targetSlot(targetSlot), .attentionButtonPresent(attentionButtonPresent),
    .latchSensorPresent(latchSensorPresent), .firstSlotDeviceNumber(firstSlotDeviceNumber),
    .slotCount(slotCount), .hotPlugCapPresent(hotPlugCapPresent), .slotLabel(slotLabel),
    .errIntEnable(errIntEnable));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard, far above the roughly 120 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input hpc_word_t got, input hpc_word_t exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one request cycle, answer sampled just after the edge that lands the ack
  task automatic acc(input logic w, input logic [7:0] a, input hpc_word_t d, input hpc_be_t be);
    @(posedge mclk);
    regReq <= 1'b1;
    regWr <= w;
    regAddr <= a;
    regWrData <= d;
    regBe <= be;
    @(posedge mclk);
    regReq <= 1'b0;
    #1;
    check(regAck, 1'b1);
    q = regRdData;
    startSeen = cmdStart;
  endtask : acc
  task automatic rd(input logic [7:0] a, input hpc_word_t exp);
    acc(1'b0, a, 32'h0, 4'h0);
    check(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input hpc_word_t d, input hpc_be_t be);
    acc(1'b1, a, d, be);
  endtask : wr
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
  endtask : do_reset
  initial begin
    {rst_b, regReq, regWr, regCfgSpace, cmdDone, errEvent, regAddr, regBe, regWrData} = '0;
    busSpeedMode = 3'h4;
    msgNumber = 5'h15;
    intSourceMap = 32'ha5a50001;
    serrSourceMap = 32'h5a5a0002;
    do_reset();
    regCfgSpace <= 1'b1;
    rd(8'h00, 32'h0);
    regCfgSpace <= 1'b0;
    wr(8'h00, 32'hffffffff, 4'hf);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h00000006);
    wr(8'h10, 32'hffffffff, 4'hf);
    rd(8'h10, 32'h01150004);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'ha5a50001);
    rd(8'h1c, 32'h5a5a0002);
    rd(8'h20, 32'h0000000f);
    for (int i = 0; i < 6; i++) rd(8'h24 + 8'(4 * i), {16'h8f00, 16'(i + 1)});
    rd(8'h3c, 32'h0);
    // first write with a byte lane enabled wins, later ones are dropped silently
    wr(8'h04, 32'h12345678, 4'hf);
    wr(8'h04, 32'hffffffff, 4'hf);
    rd(8'h04, 32'h12345678);
    wr(8'h08, 32'h11111111, 4'h0);
    wr(8'h08, 32'h00c0ffee, 4'hf);
    rd(8'h08, 32'h00c0ffee);
    wr(8'h0c, 32'hffffffff, 4'hf);
    wr(8'h0c, 32'h0, 4'hf);
    rd(8'h0c, 32'he7ff1f1f);
    check({attentionButtonPresent, latchSensorPresent}, 2'b11);
    check({firstSlotDeviceNumber, slotCount}, 10'h3ff);
    for (int i = 0; i < 6; i++) check(slotLabel[i], hpc_label_t'(11'h7ff + i));
    wr(8'h14, 32'hffff0a35, 4'h3);
    check({startSeen, commandCode, targetSlot}, {1'b1, 8'h35, 5'h0a});
    rd(8'h14, 32'h00010a35);
    @(posedge mclk) cmdDone <= 1'b1;
    @(posedge mclk) cmdDone <= 1'b0;
    rd(8'h14, 32'h00000a35);
    wr(8'h20, 32'h0, 4'hf);
    check(errIntEnable, 4'h0);
    @(posedge mclk) errEvent <= 2'h3;
    @(posedge mclk) errEvent <= 2'h0;
    wr(8'h20, 32'h00010005, 4'hf);
    rd(8'h20, 32'h00020005);
    for (int i = 0; i < 6; i++) wr(8'h24 + 8'(4 * i), 32'h5a000000 + i, 4'hf);
    for (int i = 0; i < 6; i++) rd(8'h24 + 8'(4 * i), 32'h5a000000 + i);
    // second reset reopens the write-once words; labels now count down
    do_reset();
    rd(8'h04, 32'h0);
    wr(8'h0c, 32'h01230200, 4'hf);
    rd(8'h0c, 32'h01230206);
    check({attentionButtonPresent, latchSensorPresent, firstSlotDeviceNumber}, 7'h02);
    check({slotCount, hotPlugCapPresent}, 6'h0d);
    for (int i = 0; i < 6; i++) check(slotLabel[i], hpc_label_t'(11'h123 - i));
    tally_and_finish();
  end
endmodule : tb
